// ---- dv/acs_array_model.sv ----
`timescale 1ns/10ps
module acs_comp_model
   import acs_pkg::*;
(
   // phase from the device
   input wire logic phase_one_clock,
   // wanted comparator results
   input wire logic [ACS_NCOL-1:0] sc_want,
   input wire logic [ACS_NCOL-1:0] ct_want,
   // comparator pins
   output logic [ACS_NCOL-1:0] sc_comp_pin,
   output logic [ACS_NCOL-1:0] ct_comp_pin
);
   // sc result only moves at phase one rise, held through phase two
   initial
   begin
      sc_comp_pin = '0;
      forever @(posedge phase_one_clock)
         sc_comp_pin <= sc_want;
   end
   // continuous path follows its input at once
   assign ct_comp_pin = ct_want;
endmodule

// ---- dv/acs_column_ctl_chk.sv ----
`timescale 1ns/10ps
module acs_column_ctl_chk
   import acs_pkg::*;
#(
   parameter int NCOL = ACS_NCOL,
   parameter int PHASE_CYCLES = ACS_PHASE_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // phases and column outputs
   input wire logic phase_one_clock,
   input wire logic phase_two_clock,
   input wire logic [NCOL-1:0] comp_to_digital,
   input wire logic [NCOL-1:0] column_irq,
   // switches
   input wire logic [NCOL-1:0] integ_fb_sw,
   input wire logic [NCOL-1:0] b_gnd_sw,
   input wire logic [NCOL-1:0] b_input_sw,
   input wire logic [NCOL-1:0] b_sum_sw
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // shadow of block a feedback bit, column 0 only to keep it small
   logic fb_r;
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         fb_r <= 1'b0;
      else if (reg_wr && reg_addr == ACS_ADDR_SCB_A)
         fb_r <= reg_wdata[ACS_INTEGRATOR_FEEDBACK_SWITCH_CTL_BIT];
   end

   a_phase_excl: assert property (
      !(phase_one_clock && phase_two_clock))
      else $error("phases overlap");
   a_phase_next: assert property (
      $rose(phase_one_clock) |-> ##[1:1000] $rose(phase_two_clock))
      else $error("phase two missing");
   a_fb_open: assert property (
      !fb_r && !$past(fb_r) |-> !integ_fb_sw[0])
      else $error("feedback switch closed while off");
   a_latch_hold: assert property (
      $changed(comp_to_digital) |-> $past(phase_two_clock))
      else $error("latch moved outside phase two");
   a_gnd_phase: assert property (
      b_gnd_sw != '0 |-> $past(phase_one_clock))
      else $error("branch grounded outside phase one");
   a_b_break: assert property (
      (b_gnd_sw & (b_input_sw | b_sum_sw)) == '0)
      else $error("branch ground and input together");
   a_irq_pulse: assert property (
      (column_irq & $past(column_irq)) == '0)
      else $error("interrupt wider than one cycle");
   a_irq_cause: assert property (
      column_irq != '0 |->
      $past(phase_two_clock, 2) || $past(phase_two_clock, 3))
      else $error("interrupt without phase two");
   a_rd_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");

   c_irq: cover property (column_irq[0]);
   c_fb: cover property (integ_fb_sw[0] && phase_two_clock);
   c_gnd: cover property (b_gnd_sw[0]);
endmodule

bind acs_column_ctl acs_column_ctl_chk #(.NCOL(NCOL),
   .PHASE_CYCLES(PHASE_CYCLES)) u_chk (.clk(clk), .resetn(resetn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .phase_one_clock(phase_one_clock), .phase_two_clock(phase_two_clock),
   .comp_to_digital(comp_to_digital), .column_irq(column_irq),
   .integ_fb_sw(integ_fb_sw), .b_gnd_sw(b_gnd_sw),
   .b_input_sw(b_input_sw), .b_sum_sw(b_sum_sw));

// ---- dv/acs_column_ctl_tb.sv ----
`timescale 1ns/10ps
module acs_column_ctl_tb
   import acs_pkg::*;
;
   `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
      n_mismatch++; $display("[ERR] %0t got %h want %h", $time, a, b); \
      end end
   localparam int PC = 2;
   logic clk, resetn, reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v;
   logic [3:0] sc_pin, ct_pin, sc_want, ct_want, comp, irq;
   logic [3:0] fb, gnd, bin, bsum, bsel, aref_lvl, igs;
   logic [7:0] aref, irq_cnt, irq_base;
   logic p1, p2;
   int n_mismatch, n_compared;
   // address, write data, read back
   localparam logic [23:0] ROWS [7] = '{
      {ACS_ADDR_SCB_A, 8'hA5, 8'hA5}, {ACS_ADDR_SCB_B, 8'h5A, 8'h5A},
      {ACS_ADDR_SCB_C, 8'hFF, 8'hFF}, {ACS_ADDR_SCB_D, 8'h3C, 8'h3C},
      {ACS_ADDR_CT_LATCH, 8'h81, 8'h81}, {ACS_ADDR_CMP_STATUS, 8'hF0, 8'h00},
      {8'h50, 8'hFF, 8'h00}};

   acs_column_ctl #(.NCOL(4), .PHASE_CYCLES(PC)) u_acs_column_ctl (
      .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .sc_comp_pin(sc_pin), .ct_comp_pin(ct_pin),
      .phase_one_clock(p1), .phase_two_clock(p2),
      .comp_to_digital(comp), .column_irq(irq), .integ_fb_sw(fb),
      .integ_gnd_sw(igs), .b_gnd_sw(gnd), .b_input_sw(bin),
      .b_sum_sw(bsum), .b_input_sel(bsel), .a_ref_sel(aref),
      .a_ref_comp_level(aref_lvl));
   acs_comp_model u_acs_comp_model (.phase_one_clock(p1),
      .sc_want(sc_want), .ct_want(ct_want), .sc_comp_pin(sc_pin),
      .ct_comp_pin(ct_pin));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // free-running count; tests take a base instead of clearing it
   always @(posedge clk or negedge resetn)
      if (!resetn)
         irq_cnt <= 8'h00;
      else if (irq[0])
         irq_cnt <= irq_cnt + 8'h01;

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
   endtask
   // wait for the first cycle with the wanted phase level, bounded
   task automatic wait_ph(input bit two);
      for (int i = 0; i < 100; i++)
      begin
         @(posedge clk);
         #1;
         if ((two ? p2 : p1) === 1'b1)
            break;
      end
   endtask
   task automatic finish_test();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      #(20000 * 100);
      n_mismatch++;
      finish_test();
   end

   initial
   begin
      n_mismatch = 0;
      n_compared = 0;
      irq_base = 8'h00;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      sc_want = 4'h0;
      ct_want = 4'h0;
      resetn = 1'b0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      foreach (ROWS[i])
      begin
         wr(ROWS[i][23:16], ROWS[i][15:8]);
         rd(ROWS[i][23:16]);
         `CHK(rd_v, ROWS[i][7:0])
      end
      $display("register table done");
      // branch switching on block c, off on block a, A1 back to idle
      wr(ACS_ADDR_CT_LATCH, 8'h00);
      wait_ph(1'b1);
      @(posedge clk);
      #1 `CHK(bsel[0], 1'b1)
      `CHK(aref[1:0], ACS_AREF_LOW)
      `CHK({gnd[0], bin[0], bsum[0]}, 3'b011)
      `CHK({gnd[2], bin[2], bsum[2]}, 3'b011)
      `CHK(fb[2:1], 2'b10)
      `CHK(igs[1:0], 2'b10)
      wait_ph(1'b0);
      @(posedge clk);
      #1 `CHK({gnd[2], bin[2], bsum[2]}, 3'b100)
      $display("switch gating done");
      @(posedge clk);
      resetn <= 1'b0;
      @(posedge clk);
      resetn <= 1'b1;
      rd(ACS_ADDR_SCB_A);
      `CHK(rd_v, 8'h00)
      $display("reset done");
      // feedback with offset nulling: closed in phase two only
      wr(ACS_ADDR_SCB_A, 8'h20);
      wr(ACS_ADDR_PHASE_CFG, 8'h01);
      wait_ph(1'b1);
      @(posedge clk);
      #1 `CHK(fb[0], 1'b1)
      wait_ph(1'b0);
      @(posedge clk);
      #1 `CHK(fb[0], 1'b0)
      wr(ACS_ADDR_PHASE_CFG, 8'h00);
      wait_ph(1'b0);
      @(posedge clk);
      #1 `CHK(fb[0], 1'b1)
      $display("feedback done");
      // one driver on column 0 only, column 1 left undriven
      wr(ACS_ADDR_COMP_DRIVE, 8'h01);
      irq_base = irq_cnt;
      sc_want <= 4'h3;
      repeat (40) @(posedge clk);
      #1 `CHK(comp, 4'h1)
      `CHK(irq_cnt - irq_base, 8'h01)
      rd(ACS_ADDR_CMP_STATUS);
      `CHK(rd_v, 8'h10)
      sc_want <= 4'h0;
      wait_ph(1'b0);
      `CHK(comp, 4'h1)
      $display("comparator done");
      // phase two interrupt source, write to status bits ignored
      wr(ACS_ADDR_CMP_STATUS, 8'hEF);
      rd(ACS_ADDR_CMP_STATUS);
      `CHK(rd_v[3:0], 4'hF)
      `CHK(rd_v[7:4], 4'h1)
      wait_ph(1'b0);
      irq_base = irq_cnt;
      // one column period is four phase slots
      repeat (4 * PC * 5) @(posedge clk);
      #1 `CHK(irq_cnt - irq_base, 8'h05)
      // continuous path unlatched through column 2
      wr(ACS_ADDR_SCB_C, 8'hC0);
      wr(ACS_ADDR_COMP_DRIVE, 8'h40);
      ct_want <= 4'h4;
      repeat (20) @(posedge clk);
      #1 `CHK(comp[2], 1'b1)
      `CHK(aref[5:4], ACS_AREF_COMP)
      `CHK(aref_lvl[2], 1'b1)
      $display("interrupt done");
      finish_test();
   end
endmodule

// ---- hdl/acs_column_ctl.sv ----
// Notes on behaviour
// - feedback switch bit clear keeps integrator feedback switch open always
// - bit set: feedback closed always, or only during phase two if nulling
// - branch switching off leaves the B branch a continuous path
// - switching on: ground both ends in phase one, connect in phase two
// - two-bit A reference: ground, high, low, or comparator-driven
// - one bit steers one of two neighbouring sources to B input
// - one comparator bus per column, feeding digital blocks and status
// - bus reaches digital blocks and status only through a latch
// - latch transparent during phase two high, holds from its fall
// - SC outputs always latched on chosen phase; CT only if enabled
// - status bits 7..4 show latched columns 3..0, read only
// - bits 3..0 pick interrupt: comparator bus or phase two fall
// - an undriven column bus reads low
// - SC comparator evaluated at phase one rise, held through phase two
`timescale 1ns/10ps
module acs_column_ctl
   import acs_pkg::*;
#(
   parameter int NCOL = ACS_NCOL,
   parameter int PHASE_CYCLES = ACS_PHASE_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // raw comparator outputs from the analog array
   input wire logic [NCOL-1:0] sc_comp_pin,
   input wire logic [NCOL-1:0] ct_comp_pin,
   // analog phases
   output logic phase_one_clock,
   output logic phase_two_clock,
   // latched column comparators and interrupts
   output logic [NCOL-1:0] comp_to_digital,
   output logic [NCOL-1:0] column_irq,
   // switch gating, one bit per block
   output logic [NCOL-1:0] integ_fb_sw,
   output logic [NCOL-1:0] integ_gnd_sw,
   output logic [NCOL-1:0] b_gnd_sw,
   output logic [NCOL-1:0] b_input_sw,
   output logic [NCOL-1:0] b_sum_sw,
   output logic [NCOL-1:0] b_input_sel,
   // A branch reference mux, two select bits and one comparator level bit per block
   output logic [2*NCOL-1:0] a_ref_sel,
   output logic [NCOL-1:0] a_ref_comp_level
);

   logic [NCOL-1:0] irq_sel_r;
   logic [7:0] scb_ctl_r [NCOL];
   logic [7:0] phase_cfg_r;
   logic [7:0] ct_cfg_r;
   logic [7:0] drive_cfg_r;
   logic [7:0] read_val;
   logic [2:0] wr_idx;
   logic [2:0] rd_idx;
   logic p1_rise;
   logic p2_rise;
   logic p2_fall;
   logic [NCOL-1:0] sc_filt;
   logic [NCOL-1:0] ct_filt;
   logic [NCOL-1:0] sc_hold_r;
   logic [NCOL-1:0] ct_hold_r;
   logic [NCOL-1:0] col_bus;
   logic [NCOL-1:0] col_latch_r;
   logic [NCOL-1:0] col_prev_r;
   logic [NCOL-1:0] irq_r;

   // shared address decode for writes and reads
   function automatic logic [2:0] reg_index(input logic [7:0] a,
                                            output logic hit);
      logic [2:0] idx;
      idx = ACS_IDX_NONE;
      hit = 1'b1;
      unique case (a)
         ACS_ADDR_CMP_STATUS: idx = ACS_IDX_CMP;
         ACS_ADDR_SCB_A: idx = ACS_IDX_SCB_A;
         ACS_ADDR_SCB_B: idx = ACS_IDX_SCB_B;
         ACS_ADDR_SCB_C: idx = ACS_IDX_SCB_C;
         ACS_ADDR_SCB_D: idx = ACS_IDX_SCB_D;
         ACS_ADDR_PHASE_CFG: idx = ACS_IDX_PHASE;
         ACS_ADDR_CT_LATCH: idx = ACS_IDX_CT;
         ACS_ADDR_COMP_DRIVE: idx = ACS_IDX_DRIVE;
         default: hit = 1'b0;
      endcase
      return idx;
   endfunction

   logic wr_hit;
   logic rd_hit;

   always_comb
   begin
      wr_hit = 1'b0;
      rd_hit = 1'b0;
      wr_idx = reg_index(reg_addr, wr_hit);
      rd_idx = reg_index(reg_addr, rd_hit);
   end

   // phase generator
   acs_phase_gen #(
      .PHASE_CYCLES(PHASE_CYCLES)
   ) u_phase (
      .clk(clk),
      .resetn(resetn),
      .phase_one(phase_one_clock),
      .phase_two(phase_two_clock),
      .p1_rise(p1_rise),
      .p2_rise(p2_rise),
      .p2_fall(p2_fall)
   );

   // status bits above the select field are not storage
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         irq_sel_r <= '0;
      else if (reg_wr && wr_hit && wr_idx == ACS_IDX_CMP)
         irq_sel_r <= reg_wdata[ACS_CMP_IRQ_LSB +: NCOL];
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < NCOL; i++)
            scb_ctl_r[i] <= ACS_RST_REG;
      end
      else if (reg_wr && wr_hit)
      begin
         for (int i = 0; i < NCOL; i++)
            if (wr_idx == ACS_IDX_SCB_A + 3'(i))
               scb_ctl_r[i] <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         phase_cfg_r <= ACS_RST_REG;
         ct_cfg_r <= ACS_RST_REG;
         drive_cfg_r <= ACS_RST_REG;
      end
      else if (reg_wr && wr_hit)
      begin
         if (wr_idx == ACS_IDX_PHASE)
            phase_cfg_r <= reg_wdata;
         if (wr_idx == ACS_IDX_CT)
            ct_cfg_r <= reg_wdata;
         if (wr_idx == ACS_IDX_DRIVE)
            drive_cfg_r <= reg_wdata;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb
   begin
      read_val = ACS_RD_UNMAPPED;
      if (rd_hit)
      begin
         unique case (rd_idx)
            ACS_IDX_CMP:
            begin
               read_val[ACS_CMP_COMP_LSB +: NCOL] = col_latch_r;
               read_val[ACS_CMP_IRQ_LSB +: NCOL] = irq_sel_r;
            end
            ACS_IDX_SCB_A: read_val = scb_ctl_r[0];
            ACS_IDX_SCB_B: read_val = scb_ctl_r[1];
            ACS_IDX_SCB_C: read_val = scb_ctl_r[2];
            ACS_IDX_SCB_D: read_val = scb_ctl_r[3];
            ACS_IDX_PHASE: read_val = phase_cfg_r;
            ACS_IDX_CT: read_val = ct_cfg_r;
            ACS_IDX_DRIVE: read_val = drive_cfg_r;
         endcase
      end
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         reg_rdata <= ACS_RD_UNMAPPED;
      else if (reg_rd)
         reg_rdata <= read_val;
      else
         reg_rdata <= ACS_RD_UNMAPPED;
   end

   // per column: synchronise the analog pins, latch, drive the bus
   genvar c;
   generate
      for (c = 0; c < NCOL; c++)
      begin : g_col
         logic [1:0] s1_r;
         logic [1:0] s2_r;
         logic [1:0] s3_r;
         logic [1:0] filt_r;
         logic sc_out;
         logic ct_out;
         logic ct_edge;

         // glitch filter: accept a change once stages two and three agree
         always_ff @(posedge clk or negedge resetn)
         begin
            if (!resetn)
            begin
               s1_r <= 2'h0;
               s2_r <= 2'h0;
               s3_r <= 2'h0;
               filt_r <= 2'h0;
            end
            else
            begin
               s1_r <= {ct_comp_pin[c], sc_comp_pin[c]};
               s2_r <= s1_r;
               s3_r <= s2_r;
               for (int k = 0; k < 2; k++)
                  if (s2_r[k] == s3_r[k])
                     filt_r[k] <= s3_r[k];
            end
         end

         assign sc_filt[c] = filt_r[0];
         assign ct_filt[c] = filt_r[1];

         // SC block: sample at start of selected phase and hold
         always_ff @(posedge clk or negedge resetn)
         begin
            if (!resetn)
               sc_hold_r[c] <= 1'b0;
            else if (phase_cfg_r[ACS_PCFG_OPH_LSB + c] ? p2_rise : p1_rise)
               sc_hold_r[c] <= sc_filt[c];
         end

         assign ct_edge = ct_cfg_r[ACS_CT_PH_LSB + c] ? p2_rise : p1_rise;

         always_ff @(posedge clk or negedge resetn)
         begin
            if (!resetn)
               ct_hold_r[c] <= 1'b0;
            else if (ct_edge)
               ct_hold_r[c] <= ct_filt[c];
         end

         assign sc_out = sc_hold_r[c];
         // CT output passes straight through unless its latch is on
         assign ct_out = ct_cfg_r[ACS_CT_EN_LSB + c] ? ct_hold_r[c] :
                         ct_filt[c];

         // wired-or of enabled drivers; with none enabled the bus is low.
         // two enabled drivers would be a conflict on silicon; here
         // they simply merge, software must keep to one
         assign col_bus[c] = (drive_cfg_r[ACS_DRV_SC_LSB + c] & sc_out) |
                             (drive_cfg_r[ACS_DRV_CT_LSB + c] & ct_out);

         // column latch: follows bus in phase two, keeps last value after
         always_ff @(posedge clk or negedge resetn)
         begin
            if (!resetn)
               col_latch_r[c] <= 1'b0;
            else if (phase_two_clock)
               col_latch_r[c] <= col_bus[c];
         end

         always_ff @(posedge clk or negedge resetn)
         begin
            if (!resetn)
               col_prev_r[c] <= 1'b0;
            else
               col_prev_r[c] <= col_latch_r[c];
         end

         // one-cycle interrupt pulse per column
         always_ff @(posedge clk or negedge resetn)
         begin
            if (!resetn)
               irq_r[c] <= 1'b0;
            else if (irq_sel_r[c])
               irq_r[c] <= p2_fall;
            else
               irq_r[c] <= col_latch_r[c] & ~col_prev_r[c];
         end
      end
   endgenerate

   assign comp_to_digital = col_latch_r;
   assign column_irq = irq_r;

   // switch gating; block i sits in column i
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         integ_fb_sw <= '0;
         integ_gnd_sw <= '0;
         b_gnd_sw <= '0;
         b_input_sw <= '0;
         b_sum_sw <= '0;
         b_input_sel <= '0;
         a_ref_sel <= '0;
         a_ref_comp_level <= '0;
      end
      else
      begin
         for (int i = 0; i < NCOL; i++)
         begin
            // feedback only closes with its enable bit set
            if (!scb_ctl_r[i][ACS_INTEGRATOR_FEEDBACK_SWITCH_CTL_BIT])
               integ_fb_sw[i] <= 1'b0;
            else if (phase_cfg_r[ACS_PCFG_ONULL_LSB + i])
               integ_fb_sw[i] <= phase_two_clock;
            else
               integ_fb_sw[i] <= 1'b1;
            integ_gnd_sw[i] <= scb_ctl_r[i][ACS_INTEGRATOR_GROUND_SWITCH_CTL_BIT];
            if (scb_ctl_r[i][ACS_BSW_BIT])
            begin
               b_gnd_sw[i] <= phase_one_clock;
               b_input_sw[i] <= phase_two_clock;
               b_sum_sw[i] <= phase_two_clock;
            end
            else
            begin
               b_gnd_sw[i] <= 1'b0;
               b_input_sw[i] <= 1'b1;
               b_sum_sw[i] <= 1'b1;
            end
            // which two sources this picks depends on block placement
            b_input_sel[i] <= scb_ctl_r[i][ACS_BMUX_BIT];
            a_ref_sel[2*i +: 2] <= scb_ctl_r[i][ACS_AREF_LSB +: 2];
            // comparator-driven reference uses the latched column state
            a_ref_comp_level[i] <=
               (scb_ctl_r[i][ACS_AREF_LSB +: 2] == ACS_AREF_COMP) &
               col_latch_r[i];
         end
      end
   end

endmodule

// ---- hdl/acs_phase_gen.sv ----
`timescale 1ns/10ps
module acs_phase_gen
   import acs_pkg::*;
#(
   parameter int PHASE_CYCLES = ACS_PHASE_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // phases and their edges
   output logic phase_one,
   output logic phase_two,
   output logic p1_rise,
   output logic p2_rise,
   output logic p2_fall
);

   localparam logic [ACS_PCNT_W-1:0] LAST =
      ACS_PCNT_W'(PHASE_CYCLES - 1);

   acs_phase_t state_r;
   logic [ACS_PCNT_W-1:0] cnt_r;
   logic step;

   assign step = (cnt_r == LAST);

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         cnt_r <= '0;
      else if (step)
         cnt_r <= '0;
      else
         cnt_r <= cnt_r + 1'b1;
   end

   // gaps between phases keep them from ever overlapping
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         state_r <= ACS_PH_GAP2;
      else if (step)
      begin
         unique case (state_r)
            ACS_PH_ONE: state_r <= ACS_PH_GAP1;
            ACS_PH_GAP1: state_r <= ACS_PH_TWO;
            ACS_PH_TWO: state_r <= ACS_PH_GAP2;
            ACS_PH_GAP2: state_r <= ACS_PH_ONE;
            default: state_r <= ACS_PH_GAP2;
         endcase
      end
   end

   // edge pulses line up with the first cycle of the new level
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         p1_rise <= 1'b0;
         p2_rise <= 1'b0;
         p2_fall <= 1'b0;
      end
      else
      begin
         p1_rise <= step && (state_r == ACS_PH_GAP2);
         p2_rise <= step && (state_r == ACS_PH_GAP1);
         p2_fall <= step && (state_r == ACS_PH_TWO);
      end
   end

   assign phase_one = state_r[0];
   assign phase_two = state_r[2];

endmodule

// ---- hdl/acs_pkg.sv ----
package acs_pkg;

   // array shape: one switched-capacitor block and one comparator bus
   // per analog column
   localparam int ACS_NCOL = 4;

   // register byte addresses
   localparam logic [7:0] ACS_ADDR_CMP_STATUS = 8'h64;
   localparam logic [7:0] ACS_ADDR_SCB_A = 8'h87;
   localparam logic [7:0] ACS_ADDR_SCB_B = 8'h8F;
   localparam logic [7:0] ACS_ADDR_SCB_C = 8'h93;
   localparam logic [7:0] ACS_ADDR_SCB_D = 8'h98;
   localparam logic [7:0] ACS_ADDR_PHASE_CFG = 8'hA0;
   localparam logic [7:0] ACS_ADDR_CT_LATCH = 8'hA1;
   localparam logic [7:0] ACS_ADDR_COMP_DRIVE = 8'hA2;

   // register decode indices
   localparam logic [2:0] ACS_IDX_CMP = 3'h0;
   localparam logic [2:0] ACS_IDX_SCB_A = 3'h1;
   localparam logic [2:0] ACS_IDX_SCB_B = 3'h2;
   localparam logic [2:0] ACS_IDX_SCB_C = 3'h3;
   localparam logic [2:0] ACS_IDX_SCB_D = 3'h4;
   localparam logic [2:0] ACS_IDX_PHASE = 3'h5;
   localparam logic [2:0] ACS_IDX_CT = 3'h6;
   localparam logic [2:0] ACS_IDX_DRIVE = 3'h7;
   localparam logic [2:0] ACS_IDX_NONE = 3'h7;

   // reset values
   localparam logic [7:0] ACS_RST_REG = 8'h00;
   localparam logic [7:0] ACS_RD_UNMAPPED = 8'h00;

   // switch control field positions
   localparam int ACS_AREF_LSB = 6;
   localparam int ACS_INTEGRATOR_FEEDBACK_SWITCH_CTL_BIT = 5;
   localparam int ACS_INTEGRATOR_GROUND_SWITCH_CTL_BIT = 4;
   localparam int ACS_BSW_BIT = 3;
   localparam int ACS_BMUX_BIT = 2;

   // status / select field positions
   localparam int ACS_CMP_COMP_LSB = 4;
   localparam int ACS_CMP_IRQ_LSB = 0;
   localparam int ACS_PCFG_ONULL_LSB = 0;
   localparam int ACS_PCFG_OPH_LSB = 4;
   localparam int ACS_CT_EN_LSB = 0;
   localparam int ACS_CT_PH_LSB = 4;
   localparam int ACS_DRV_SC_LSB = 0;
   localparam int ACS_DRV_CT_LSB = 4;

   // reference select codes
   localparam logic [1:0] ACS_AREF_AGND = 2'h0;
   localparam logic [1:0] ACS_AREF_HIGH = 2'h1;
   localparam logic [1:0] ACS_AREF_LOW = 2'h2;
   localparam logic [1:0] ACS_AREF_COMP = 2'h3;

   // timing: each phase and each gap lasts one quarter of column period
   localparam int ACS_CLK_PERIOD_NS = 100;
   localparam int ACS_PHASE_TIME_NS = 1000;
   localparam int ACS_PHASE_CYC_RAW = ACS_PHASE_TIME_NS / ACS_CLK_PERIOD_NS;
   localparam int ACS_PHASE_CYC = (ACS_PHASE_CYC_RAW < 1) ? 1 :
                                  ACS_PHASE_CYC_RAW;
   localparam int ACS_PCNT_W = 16;

   typedef enum logic [3:0]
   {
      ACS_PH_ONE = 4'b0001,
      ACS_PH_GAP1 = 4'b0010,
      ACS_PH_TWO = 4'b0100,
      ACS_PH_GAP2 = 4'b1000
   } acs_phase_t;

endpackage
